// file: bkc_buck_ctrl.sv
// buck regulator digital control: serial register port, start-up, shutdown and protection
//
// Overview of operation
// [R1] Answer only transfers addressed to seven-bit target 0x60.
// [R2] Address byte 0xC0 writes, 0xC1 reads.
// [R3] Serial port works up to 3.4 Mbit/s.
// [R4] Converter runs only while enable pin and enable bit are both high.
// [R5] Pin low, undervoltage, over-temperature or enable bit 0 shut down.
// [R6] Shutdown first blocks the fault signaling path.
// [R7] Start reference, regulator, circuits in order, then 165 us soft start.
// [R8] Seven-bit setpoint code, 0.6 V to 1.235 V in 5 mV, default 0.8 V.
// [R9] Setpoint only takes effect once the unlock bit is 1.
// [R10] Three-bit field picks one of six frequencies, 1.25 MHz default.
// [R11] Window bit 1 checks over and under, 0 only under.
// [R12] Power-good released only inside 90 to 110 percent window.
// [R13] Input overvoltage stops at 6.3 V, restarts at 6.2 V, unless disabled.
// [R14] Mode bit 1 forced continuous, 0 pulse skipping.
// [R15] Pulse skipping turns low-side off when inductor current reverses.
// [R16] Discharge bit picks load or internal pull-down while pin low.
// [R17] After 12.7 A hit, hold high-side off until below 7.5 A.
// [R18] Consecutive current-limit cycles shut the converter down, latched.
// [R19] Over-temperature shuts down, latched.
// [R20] Undervoltage lockout holds the converter off.
// [R21] Slew select bit steers the reference ramp on setpoint change; the code has no ramp, the new code goes straight out.
// [R22] Master writes the second control register alone, never in a burst.
// [R23] Six frequency codes assigned, two reserved codes.
// [R24] Latched faults clear on pin or supply cycle, or enable rewrite.
`timescale 1ns/1ps
module bkc_buck_ctrl #(
  parameter int unsigned OCP_HITS = 4
) (
  // core clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // serial link, sampled on its own clock
  input wire logic i2cSampleClk,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // analog comparator and timing inputs
  input wire bkc_pkg::bkc_sense_t sense,
  // converter controls
  output bkc_pkg::bkc_drive_t drive,
  output logic powerOkOut
);

  typedef struct packed {
    logic rstS1;
    logic rstS2;
    logic sclS1;
    logic sclS2;
    logic sclS3;
    logic sdaS1;
    logic sdaS2;
    logic sdaS3;
    bkc_pkg::bkc_lk_t st;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic havePtr;
    logic isRead;
    logic nack;
    logic sdaDrive;
    bkc_pkg::bkc_regs_t regs;
    logic dirty;
    bkc_pkg::bkc_regs_t xfer;
    logic req;
    logic ackS1;
    logic ackS2;
  } bkc_link_t;

  typedef struct packed {
    bkc_pkg::bkc_sense_t s1;
    bkc_pkg::bkc_sense_t s2;
    logic cycPrev;
    logic reqS1;
    logic reqS2;
    logic reqS3;
    logic ack;
    bkc_pkg::bkc_regs_t cfg;
    bkc_pkg::bkc_pwr_t st;
    logic [11:0] timer;
    logic ovpHold;
    logic hsBlank;
    logic hitCycle;
    logic [3:0] hitCnt;
    logic faultLatch;
    bkc_pkg::bkc_drive_t drv;
  } bkc_core_t;

  bkc_link_t l, ln;
  bkc_core_t c, cn;

  function automatic logic [7:0] readReg(bkc_pkg::bkc_regs_t r, logic [7:0] a);
    case (a)
      bkc_pkg::REG_SETPOINT: readReg = r.setpoint;
      bkc_pkg::REG_CTRL1: readReg = r.ctrl1;
      bkc_pkg::REG_CTRL2: readReg = r.ctrl2;
      default: readReg = 8'h00;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // link domain: serial target, register copy and hand-off to the core

  logic sclRise, sclFall, busStart, busStop;
  assign sclRise = l.sclS2 && !l.sclS3;
  assign sclFall = !l.sclS2 && l.sclS3;
  // start and stop are sda edges while scl stays high
  assign busStart = l.sclS2 && l.sclS3 && !l.sdaS2 && l.sdaS3;
  assign busStop = l.sclS2 && l.sclS3 && l.sdaS2 && !l.sdaS3;

  always_comb begin
    logic [7:0] nextByte;
    nextByte = readReg(l.regs, l.ptr);
    ln = l;
    ln.rstS1 = rst;
    ln.rstS2 = l.rstS1;
    ln.sclS1 = sclIn;
    ln.sclS2 = l.sclS1;
    ln.sclS3 = l.sclS2;
    ln.sdaS1 = sdaIn;
    ln.sdaS2 = l.sdaS1;
    ln.sdaS3 = l.sdaS2;
    ln.ackS1 = c.ack;
    ln.ackS2 = l.ackS1;
    if (l.rstS2) begin
      ln.st = bkc_pkg::LK_IDLE;
      ln.bitCnt = 4'h0;
      ln.shift = 8'h00;
      ln.ptr = 8'h00;
      ln.havePtr = 1'b0;
      ln.isRead = 1'b0;
      ln.nack = 1'b0;
      ln.sdaDrive = 1'b0;
      ln.regs = {1'b0, bkc_pkg::CTRL2_RST, bkc_pkg::CTRL1_RST, bkc_pkg::SETPOINT_RST};
      ln.dirty = 1'b0;
      ln.xfer = ln.regs;
      ln.req = 1'b0;
    end else begin
      // a new snapshot only leaves once the core returned the last one
      if (l.dirty && (l.req == l.ackS2)) begin
        ln.xfer = l.regs;
        ln.req = !l.req;
        ln.dirty = 1'b0;
        ln.regs.enRise = 1'b0;
      end
      if (busStart) begin
        ln.st = bkc_pkg::LK_ADDR;
        ln.bitCnt = 4'h0;
        ln.havePtr = 1'b0;
        ln.sdaDrive = 1'b0;
      end else if (busStop) begin
        ln.st = bkc_pkg::LK_IDLE;
        ln.sdaDrive = 1'b0;
      end else begin
        case (l.st)
          bkc_pkg::LK_ADDR, bkc_pkg::LK_WRITE: begin
            if (sclRise) begin
              ln.shift = {l.shift[6:0], l.sdaS2};
              ln.bitCnt = l.bitCnt + 4'h1;
            end else if (sclFall && l.bitCnt == bkc_pkg::BIT_LAST) begin
              if (l.st == bkc_pkg::LK_ADDR) begin
                if (l.shift[7:1] == bkc_pkg::I2C_ADDR) begin // [R1]
                  ln.isRead = l.shift[0]; // [R2]
                  ln.sdaDrive = 1'b1;
                  ln.st = bkc_pkg::LK_ACK;
                end else begin
                  ln.st = bkc_pkg::LK_IDLE; // [R1]
                end
              end else begin
                if (!l.havePtr) begin
                  ln.ptr = l.shift;
                  ln.havePtr = 1'b1;
                end else begin
                  case (l.ptr)
                    bkc_pkg::REG_SETPOINT: begin
                      // rewrite of enable from 0 to 1 releases a latched fault
                      if (!l.regs.setpoint[bkc_pkg::EN_BIT] && l.shift[bkc_pkg::EN_BIT]) begin
                        ln.regs.enRise = 1'b1; // [R24]
                      end
                      ln.regs.setpoint = l.shift;
                    end
                    bkc_pkg::REG_CTRL1: ln.regs.ctrl1 = l.shift;
                    bkc_pkg::REG_CTRL2: ln.regs.ctrl2 = l.shift; // [R21]
                    default: ln.regs = ln.regs;
                  endcase
                  ln.dirty = 1'b1;
                  ln.ptr = l.ptr + 8'h01;
                end
                ln.sdaDrive = 1'b1;
                ln.st = bkc_pkg::LK_ACK;
              end
            end
          end
          bkc_pkg::LK_ACK: begin
            if (sclFall) begin
              ln.bitCnt = 4'h0;
              if (l.isRead) begin
                ln.shift = nextByte;
                ln.ptr = l.ptr + 8'h01;
                ln.sdaDrive = !nextByte[7];
                ln.st = bkc_pkg::LK_READ;
              end else begin
                ln.sdaDrive = 1'b0;
                ln.st = bkc_pkg::LK_WRITE;
              end
            end
          end
          bkc_pkg::LK_READ: begin
            if (sclRise) begin
              ln.bitCnt = l.bitCnt + 4'h1;
            end else if (sclFall) begin
              if (l.bitCnt == bkc_pkg::BIT_LAST) begin
                ln.sdaDrive = 1'b0;
                ln.st = bkc_pkg::LK_RACK;
              end else begin
                ln.sdaDrive = !l.shift[3'(4'h7 - l.bitCnt)];
              end
            end
          end
          bkc_pkg::LK_RACK: begin
            if (sclRise) begin
              ln.nack = l.sdaS2;
            end else if (sclFall) begin
              if (l.nack) begin
                ln.st = bkc_pkg::LK_IDLE;
              end else begin
                ln.bitCnt = 4'h0;
                ln.shift = nextByte;
                ln.ptr = l.ptr + 8'h01;
                ln.sdaDrive = !nextByte[7];
                ln.st = bkc_pkg::LK_READ;
              end
            end
          end
          bkc_pkg::LK_IDLE: ln.sdaDrive = 1'b0;
          default: ln.st = bkc_pkg::LK_IDLE;
        endcase
      end
    end
  end

  // oversampling clock well above 3.4 Mbit/s keeps every bit several samples wide
  always_ff @(posedge i2cSampleClk) begin // [R3]
    l <= ln;
  end

  assign sdaOut = 1'b0;
  assign sdaOe = l.sdaDrive;

  a_foreign_addr_quiet: assert property (@(posedge i2cSampleClk) disable iff (l.rstS2) // [R1]
    (l.st == bkc_pkg::LK_ADDR && sclFall && !busStart && !busStop
     && l.bitCnt == bkc_pkg::BIT_LAST && l.shift[7:1] != bkc_pkg::I2C_ADDR)
    |=> !sdaOe && l.st == bkc_pkg::LK_IDLE)
    else $error("foreign address was acknowledged");

  a_read_dir_bit: assert property (@(posedge i2cSampleClk) disable iff (l.rstS2) // [R2]
    (l.st == bkc_pkg::LK_ADDR && sclFall && !busStart && !busStop
     && l.bitCnt == bkc_pkg::BIT_LAST && l.shift == {bkc_pkg::I2C_ADDR, 1'b1})
    |=> l.isRead && sdaOe)
    else $error("read address byte not taken as read");

  //////////////////////////////////////////////////////////////////////////////
  // core domain: sequencing, protection and analog controls

  logic newCfg, enBit, startOk, active, cycEdge;
  assign newCfg = c.reqS2 != c.reqS3;
  assign enBit = c.cfg.setpoint[bkc_pkg::EN_BIT];
  assign active = !(c.st == bkc_pkg::ST_OFF || c.st == bkc_pkg::ST_STOP);
  assign cycEdge = c.s2.cycleStart && !c.cycPrev;
  assign startOk = c.s2.enPin && enBit && c.s2.uvloOk && !c.ovpHold && !c.faultLatch; // [R4] [R20]

  always_comb begin
    logic clearFault, setFault, hitNow;
    logic [3:0] hitSum;
    clearFault = 1'b0;
    setFault = 1'b0;
    hitNow = 1'b0;
    hitSum = 4'h0;
    cn = c;
    cn.s1 = sense;
    cn.s2 = c.s1;
    cn.cycPrev = c.s2.cycleStart;
    cn.reqS1 = l.req;
    cn.reqS2 = c.reqS1;
    cn.reqS3 = c.reqS2;
    if (rst) begin
      cn.ack = 1'b0;
      cn.cfg = {1'b0, bkc_pkg::CTRL2_RST, bkc_pkg::CTRL1_RST, bkc_pkg::SETPOINT_RST};
      cn.st = bkc_pkg::ST_OFF;
      cn.timer = 12'h000;
      cn.ovpHold = 1'b0;
      cn.hsBlank = 1'b0;
      cn.hitCycle = 1'b0;
      cn.hitCnt = 4'h0;
      cn.faultLatch = 1'b0;
    end else begin
      // snapshot is stable while req and ack differ
      cn.ack = c.reqS2;
      if (newCfg) begin
        cn.cfg = l.xfer;
      end
      if (c.cfg.ctrl1[bkc_pkg::OVP_DIS_BIT]) begin
        cn.ovpHold = 1'b0; // [R13]
      end else if (c.s2.vinAbove63) begin
        cn.ovpHold = 1'b1; // [R13]
      end else if (!c.s2.vinAbove62) begin
        cn.ovpHold = 1'b0; // [R13]
      end
      if (c.s2.curLimit) begin
        cn.hsBlank = 1'b1; // [R17]
      end else if (c.s2.curBelow75) begin
        cn.hsBlank = 1'b0; // [R17]
      end
      // count switching cycles that hit the limit back to back
      hitNow = c.hitCycle || c.s2.curLimit;
      hitSum = c.hitCnt + 4'h1;
      if (!active) begin
        cn.hitCycle = 1'b0;
        cn.hitCnt = 4'h0;
      end else if (cycEdge) begin
        cn.hitCycle = 1'b0;
        cn.hitCnt = hitNow ? hitSum : 4'h0;
        setFault = hitNow && (hitSum >= 4'(OCP_HITS)); // [R18]
      end else begin
        cn.hitCycle = hitNow;
      end
      if (active && c.s2.overTemp) begin
        setFault = 1'b1; // [R19]
      end
      clearFault = !c.s2.enPin || !c.s2.uvloOk || !enBit || (newCfg && l.xfer.enRise); // [R24]
      // an event in the clearing cycle still latches
      if (setFault) begin
        cn.faultLatch = 1'b1;
      end else if (clearFault) begin
        cn.faultLatch = 1'b0;
      end
      if (c.timer != 12'h000) begin
        cn.timer = c.timer - 12'h001;
      end
      case (c.st)
        bkc_pkg::ST_OFF: begin
          if (startOk) begin
            cn.st = bkc_pkg::ST_REF; // [R7]
            cn.timer = 12'(bkc_pkg::STEP_CYCLES);
          end
        end
        bkc_pkg::ST_REF, bkc_pkg::ST_LDO, bkc_pkg::ST_CIRC, bkc_pkg::ST_SOFT,
        bkc_pkg::ST_RUN: begin
          if (!startOk || setFault) begin
            cn.st = bkc_pkg::ST_STOP; // [R5]
          end else if (c.timer == 12'h000) begin
            case (c.st)
              bkc_pkg::ST_REF: begin
                cn.st = bkc_pkg::ST_LDO; // [R7]
                cn.timer = 12'(bkc_pkg::STEP_CYCLES);
              end
              bkc_pkg::ST_LDO: begin
                cn.st = bkc_pkg::ST_CIRC; // [R7]
                cn.timer = 12'(bkc_pkg::STEP_CYCLES);
              end
              bkc_pkg::ST_CIRC: begin
                cn.st = bkc_pkg::ST_SOFT; // [R7]
                cn.timer = 12'(bkc_pkg::SS_CYCLES - 1);
              end
              bkc_pkg::ST_SOFT: cn.st = bkc_pkg::ST_RUN;
              default: cn.st = c.st;
            endcase
          end
        end
        bkc_pkg::ST_STOP: cn.st = bkc_pkg::ST_OFF; // [R6]
        default: cn.st = bkc_pkg::ST_OFF;
      endcase
    end
    // outputs are registered from the next state
    cn.drv.refEn = cn.st inside {bkc_pkg::ST_REF, bkc_pkg::ST_LDO, bkc_pkg::ST_CIRC,
                                 bkc_pkg::ST_SOFT, bkc_pkg::ST_RUN};
    cn.drv.ldoEn = cn.st inside {bkc_pkg::ST_LDO, bkc_pkg::ST_CIRC, bkc_pkg::ST_SOFT,
                                 bkc_pkg::ST_RUN};
    cn.drv.circEn = cn.st inside {bkc_pkg::ST_CIRC, bkc_pkg::ST_SOFT, bkc_pkg::ST_RUN};
    cn.drv.softStart = cn.st == bkc_pkg::ST_SOFT;
    cn.drv.switching = cn.st inside {bkc_pkg::ST_SOFT, bkc_pkg::ST_RUN};
    cn.drv.signalBlock = cn.st inside {bkc_pkg::ST_OFF, bkc_pkg::ST_STOP}; // [R6]
    cn.drv.hsAllow = cn.drv.switching && !cn.hsBlank; // [R17]
    cn.drv.forcedCont = cn.cfg.ctrl1[bkc_pkg::FORCED_BIT]; // [R14]
    // sensed levels only from the second synchroniser stage
    cn.drv.lsAllow = cn.drv.switching
                     && (cn.drv.forcedCont || !c.s2.curReverse); // [R15]
    cn.drv.pulldownEn = !c.s2.enPin && cn.cfg.ctrl2[bkc_pkg::DISCH_BIT]; // [R16]
    cn.drv.powerOkOe = !(cn.st == bkc_pkg::ST_RUN && !c.s2.voutUnder // [R12]
                         && !(cn.cfg.ctrl1[bkc_pkg::GOOD_BOTH_BIT] && c.s2.voutOver)); // [R11]
    // locked setpoint stays at the default code
    cn.drv.setpointCode = cn.cfg.ctrl2[bkc_pkg::UNLOCK_BIT] ? cn.cfg.setpoint[6:0]
                                                            : bkc_pkg::CODE_DEFAULT; // [R8] [R9]
    cn.drv.freqSel = (cn.cfg.ctrl1[7:5] > bkc_pkg::FREQ_2M20) ? bkc_pkg::FREQ_1M25
                                                             : cn.cfg.ctrl1[7:5]; // [R10] [R23]
  end

  always_ff @(posedge core_clk) begin
    c <= cn;
  end

  assign drive = c.drv;
  assign powerOkOut = 1'b0;

  a_run_needs_both: assert property (@(posedge core_clk) disable iff (rst) // [R4]
    (active && (!enBit || !c.s2.enPin)) |=> c.st == bkc_pkg::ST_STOP)
    else $error("converter kept running without both enables");

  a_stop_blocks: assert property (@(posedge core_clk) disable iff (rst) // [R6]
    (c.st == bkc_pkg::ST_STOP) |-> drive.signalBlock && drive.powerOkOe
      ##1 c.st == bkc_pkg::ST_OFF)
    else $error("shutdown did not block signaling first");

  a_start_order: assert property (@(posedge core_clk) disable iff (rst) // [R7]
    $rose(drive.softStart) |-> $past(drive.circEn) && $past(drive.ldoEn) && $past(drive.refEn))
    else $error("soft start before reference, regulator and circuits");

  a_soft_len: assert property (@(posedge core_clk) disable iff (rst) // [R7]
    (c.st == bkc_pkg::ST_SOFT) |-> c.timer < 12'(bkc_pkg::SS_CYCLES))
    else $error("soft start longer than allowed");

  a_locked_default: assert property (@(posedge core_clk) disable iff (rst) // [R9]
    !c.cfg.ctrl2[bkc_pkg::UNLOCK_BIT] |-> drive.setpointCode == bkc_pkg::CODE_DEFAULT)
    else $error("setpoint moved while locked");

  a_good_window: assert property (@(posedge core_clk) disable iff (rst) // [R12]
    !drive.powerOkOe |-> c.st == bkc_pkg::ST_RUN && !$past(c.s2.voutUnder)
      && !(c.cfg.ctrl1[bkc_pkg::GOOD_BOTH_BIT] && $past(c.s2.voutOver)))
    else $error("power good released outside window");

  a_ovp_trip: assert property (@(posedge core_clk) disable iff (rst) // [R13]
    (!c.cfg.ctrl1[bkc_pkg::OVP_DIS_BIT] && c.s2.vinAbove63) |=> c.ovpHold ##1 !active)
    else $error("input overvoltage did not stop converter");

  a_pulse_skip_ls: assert property (@(posedge core_clk) disable iff (rst) // [R15]
    (!c.cfg.ctrl1[bkc_pkg::FORCED_BIT] && c.s2.curReverse) |=> !drive.lsAllow || drive.forcedCont)
    else $error("low side on with reversed current");

  a_hs_hold: assert property (@(posedge core_clk) disable iff (rst) // [R17]
    c.s2.curLimit |=> !drive.hsAllow)
    else $error("high side allowed after limit hit");

  a_temp_latch: assert property (@(posedge core_clk) disable iff (rst) // [R19]
    (active && c.s2.overTemp) |=> c.faultLatch && c.st == bkc_pkg::ST_STOP)
    else $error("over-temperature not latched");

endmodule // bkc_buck_ctrl

// file: bkc_pkg.sv
// package: register map, field layout, timing and shared types of the buck control block
package bkc_pkg;
  // serial target address and register offsets
  localparam logic [6:0] I2C_ADDR = 7'h60;
  localparam logic [7:0] REG_SETPOINT = 8'h01;
  localparam logic [7:0] REG_CTRL1 = 8'h02;
  localparam logic [7:0] REG_CTRL2 = 8'h03;
  // values after reset
  localparam logic [7:0] SETPOINT_RST = 8'hA8;
  localparam logic [7:0] CTRL1_RST = 8'h45;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [6:0] CODE_DEFAULT = 7'h28;
  // field positions
  localparam int EN_BIT = 7;
  localparam int FREQ_LSB = 5;
  localparam int GOOD_BOTH_BIT = 2;
  localparam int OVP_DIS_BIT = 1;
  localparam int FORCED_BIT = 0;
  localparam int UNLOCK_BIT = 5;
  localparam int DISCH_BIT = 4;
  // switching frequency codes, 3'h6 and 3'h7 reserved
  localparam logic [2:0] FREQ_0M85 = 3'h0;
  localparam logic [2:0] FREQ_1M11 = 3'h1;
  localparam logic [2:0] FREQ_1M25 = 3'h2;
  localparam logic [2:0] FREQ_1M67 = 3'h3;
  localparam logic [2:0] FREQ_2M00 = 3'h4;
  localparam logic [2:0] FREQ_2M20 = 3'h5;
  // timing at the core clock
  localparam int CLK_PERIOD_NS = 100;
  localparam int SS_TIME_NS = 165000;
  localparam int SS_CYCLES = SS_TIME_NS / CLK_PERIOD_NS;
  localparam int STEP_TIME_NS = 2000;
  localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] BIT_LAST = 4'h8;

  typedef struct packed {
    logic enRise;
    logic [7:0] ctrl2;
    logic [7:0] ctrl1;
    logic [7:0] setpoint;
  } bkc_regs_t;

  typedef struct packed {
    logic enPin;
    logic uvloOk;
    logic overTemp;
    logic vinAbove63;
    logic vinAbove62;
    logic curLimit;
    logic curBelow75;
    logic curReverse;
    logic cycleStart;
    logic voutUnder;
    logic voutOver;
  } bkc_sense_t;

  typedef struct packed {
    logic refEn;
    logic ldoEn;
    logic circEn;
    logic softStart;
    logic switching;
    logic signalBlock;
    logic hsAllow;
    logic lsAllow;
    logic forcedCont;
    logic pulldownEn;
    logic powerOkOe;
    logic [6:0] setpointCode;
    logic [2:0] freqSel;
  } bkc_drive_t;

  typedef enum logic [6:0] {
    ST_OFF = 7'b000_0001, ST_REF = 7'b000_0010, ST_LDO = 7'b000_0100,
    ST_CIRC = 7'b000_1000, ST_SOFT = 7'b001_0000, ST_RUN = 7'b010_0000,
    ST_STOP = 7'b100_0000
  } bkc_pwr_t;

  typedef enum logic [5:0] {
    LK_IDLE = 6'b00_0001, LK_ADDR = 6'b00_0010, LK_ACK = 6'b00_0100,
    LK_WRITE = 6'b00_1000, LK_READ = 6'b01_0000, LK_RACK = 6'b10_0000
  } bkc_lk_t;
endpackage

// file: bkc_i2c_master.sv
// serial bus master model facing the link pins of the buck control block
`timescale 1ns/1ps
module bkc_i2c_master (
  // link pins
  output logic scl,
  output logic sdaLine,
  input wire logic sdaOe
);
  logic mLow = 1'b0;
  // pull-up: a released line reads high, never the last value
  assign sdaLine = !(mLow || sdaOe);
  initial scl = 1'b1;
  ////////////////////////////////////////
  // 300 ns bit, just under the top rate
  task automatic clkBit(input logic b, output logic r);
    #75 mLow = !b;
    #75 scl = 1'b1;
    #75 r = sdaLine;
    #75 scl = 1'b0;
  endtask
  // start or repeated start
  task automatic start();
    #75 mLow = 1'b0;
    #75 scl = 1'b1;
    #75 mLow = 1'b1;
    #75 scl = 1'b0;
  endtask
  task automatic stop();
    #75 mLow = 1'b1;
    #75 scl = 1'b1;
    #75 mLow = 1'b0;
    #75;
  endtask
  // msb first; ninth bit released for the target ack, or the master ack
  task automatic xfer(input logic [7:0] tx, input logic b9, output logic [7:0] rx,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clkBit(tx[i], r);
      rx[i] = r;
    end
    clkBit(b9, r);
    ack = !r;
  endtask
endmodule // bkc_i2c_master

// file: bkc_buck_ctrl_bench.sv
// self-checking bench for the buck control block
`timescale 1ns/1ps
module bkc_buck_ctrl_bench;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic i2cSampleClk = 1'b0;
  logic scl;
  logic sda;
  logic sdaOe;
  logic ack;
  logic [7:0] rx;
  bkc_pkg::bkc_sense_t sen;
  bkc_pkg::bkc_drive_t drive;
  int err_total = 0;
  int checked = 0;

  // small hit count keeps the current-limit case short
  bkc_buck_ctrl #(.OCP_HITS(2)) bkc_buck_ctrl_inst (
    .core_clk(core_clk), .rst(rst), .i2cSampleClk(i2cSampleClk), .sclIn(scl),
    .sdaIn(sda), .sdaOut(), .sdaOe(sdaOe), .sense(sen), .drive(drive), .powerOkOut()
  );
  bkc_i2c_master bkc_i2c_master_inst (.scl(scl), .sdaLine(sda), .sdaOe(sdaOe));

  initial forever #50 core_clk = !core_clk;
  // odd offset so the link clock drifts against the core clock
  initial begin
    #1.3;
    forever #3 i2cSampleClk = !i2cSampleClk;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got 0x%0h expected 0x%0h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] off, input logic [7:0] d);
    logic [2:0] a;
    bkc_i2c_master_inst.start();
    bkc_i2c_master_inst.xfer(8'hC0, 1'b1, rx, a[2]);
    bkc_i2c_master_inst.xfer(off, 1'b1, rx, a[1]);
    bkc_i2c_master_inst.xfer(d, 1'b1, rx, a[0]);
    bkc_i2c_master_inst.stop();
    chk(a, 3'h7);
    cyc(6);
  endtask
  task automatic rdChk(input logic [7:0] off, input logic [7:0] exp);
    bkc_i2c_master_inst.start();
    bkc_i2c_master_inst.xfer(8'hC0, 1'b1, rx, ack);
    bkc_i2c_master_inst.xfer(off, 1'b1, rx, ack);
    bkc_i2c_master_inst.start();
    bkc_i2c_master_inst.xfer(8'hC1, 1'b1, rx, ack);
    bkc_i2c_master_inst.xfer(8'hFF, 1'b1, rx, ack);
    bkc_i2c_master_inst.stop();
    chk(rx, exp);
    cyc(2);
  endtask
  // start-up walk, soft start timed to the cycle
  task automatic up();
    int n;
    for (n = 0; !drive.refEn && n < 60; n++)
      cyc(1);
    chk(drive.ldoEn, 1'b0);
    for (n = 0; !drive.softStart && n < 200; n++)
      cyc(1);
    chk({drive.ldoEn, drive.circEn, drive.switching}, 3'h7);
    for (n = 0; drive.softStart && n < 3000; n++)
      cyc(1);
    chk(n[15:0], 16'h0672);
    cyc(2);
    chk({drive.switching, drive.powerOkOe}, 2'h2);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////
  // five start-ups of 1.7k cycles plus link traffic stay well inside this
  initial begin
    #5_000_000;
    err_total++;
    wrap_up();
  end

  initial begin
    sen = '0;
    sen.uvloOk = 1'b1;
    repeat (6) @(posedge core_clk);
    #1 rst = 1'b0;
    cyc(3);
    chk({drive.signalBlock, drive.powerOkOe, drive.refEn}, 3'h6);
    chk({drive.setpointCode, drive.freqSel, drive.forcedCont}, 11'h285);
    rdChk(8'h01, 8'hA8);
    rdChk(8'h02, 8'h45);
    rdChk(8'h03, 8'h00);
    rdChk(8'h07, 8'h00);
    bkc_i2c_master_inst.start();
    bkc_i2c_master_inst.xfer(8'hC2, 1'b1, rx, ack);
    bkc_i2c_master_inst.stop();
    chk(ack, 1'b0);
    wr(8'h01, 8'hBC);
    chk(drive.setpointCode, 7'h28);
    rdChk(8'h01, 8'hBC);
    wr(8'h03, 8'h20);
    wr(8'h01, 8'hBC);
    chk(drive.setpointCode, 7'h3C);
    for (int f = 0; f < 8; f++) begin
      wr(8'h02, {f[2:0], 5'h05});
      chk(drive.freqSel, f < 6 ? f[2:0] : 3'h2);
    end
    sen.enPin = 1'b1;
    up();
    sen.voutOver = 1'b1;
    cyc(4);
    chk(drive.powerOkOe, 1'b1);
    wr(8'h02, 8'h40);
    chk({drive.powerOkOe, drive.forcedCont}, 2'h0);
    sen.voutUnder = 1'b1;
    cyc(4);
    chk(drive.powerOkOe, 1'b1);
    sen.voutOver = 1'b0;
    sen.voutUnder = 1'b0;
    sen.curReverse = 1'b1;
    cyc(4);
    chk(drive.lsAllow, 1'b0);
    sen.curReverse = 1'b0;
    sen.curLimit = 1'b1;
    cyc(4);
    chk({drive.lsAllow, drive.hsAllow}, 2'h2);
    sen.curLimit = 1'b0;
    cyc(4);
    chk(drive.hsAllow, 1'b0);
    sen.curBelow75 = 1'b1;
    cyc(4);
    chk(drive.hsAllow, 1'b1);
    sen.vinAbove62 = 1'b1;
    sen.vinAbove63 = 1'b1;
    cyc(4);
    chk(drive.switching, 1'b0);
    sen.vinAbove63 = 1'b0;
    cyc(30);
    chk(drive.refEn, 1'b0);
    sen.vinAbove62 = 1'b0;
    up();
    for (int i = 0; i < 2; i++) begin
      chk(drive.switching, 1'b1);
      sen.curLimit = 1'b1;
      sen.cycleStart = 1'b1;
      cyc(2);
      sen.cycleStart = 1'b0;
      cyc(2);
    end
    cyc(2);
    chk({drive.switching, drive.signalBlock}, 2'h1);
    sen.curLimit = 1'b0;
    cyc(30);
    chk(drive.refEn, 1'b0);
    wr(8'h01, 8'h3C);
    wr(8'h01, 8'hBC);
    up();
    sen.overTemp = 1'b1;
    cyc(4);
    chk(drive.switching, 1'b0);
    sen.overTemp = 1'b0;
    cyc(30);
    chk(drive.refEn, 1'b0);
    sen.enPin = 1'b0;
    cyc(4);
    chk(drive.pulldownEn, 1'b0);
    wr(8'h03, 8'h30);
    chk(drive.pulldownEn, 1'b1);
    sen.enPin = 1'b1;
    up();
    chk(drive.pulldownEn, 1'b0);
    wr(8'h01, 8'h3C);
    chk({drive.switching, drive.signalBlock}, 2'h1);
    sen.uvloOk = 1'b0;
    wr(8'h01, 8'hBC);
    cyc(30);
    chk(drive.refEn, 1'b0);
    sen.uvloOk = 1'b1;
    up();
    wrap_up();
  end
endmodule // bkc_buck_ctrl_bench
